/* File: src/swspi_consts.svh */
`ifndef SWSPI_CONSTS_SVH
`define SWSPI_CONSTS_SVH
`define SWSPI_WORD_BITS 16
`define SWSPI_WD_BIT 15
`define SWSPI_ADDR_HI 12
`define SWSPI_ADDR_LO 9
`define SWSPI_NUM_SO_REGS 8
`define SWSPI_SEL_OFF 2'h0
`define SWSPI_SEL_CH0 2'h1
`define SWSPI_SEL_CH1 2'h2
`define SWSPI_SEL_TEMP 2'h3
`define SWSPI_CLK_NS 20
`define SWSPI_WDTO_US 32
`define SWSPI_WDTO_CYC ((`SWSPI_WDTO_US * 1000) / `SWSPI_CLK_NS)
`define SWSPI_TIN_US 200
`define SWSPI_TIN_CYC ((`SWSPI_TIN_US * 1000) / `SWSPI_CLK_NS)
`define SWSPI_CLKFAIL_US 20
`define SWSPI_CLKFAIL_CYC ((`SWSPI_CLKFAIL_US * 1000) / `SWSPI_CLK_NS)
`define SWSPI_HDIV 4
`endif

/* File: src/swspi_pkg.sv */
package swspi_pkg;
	typedef logic [15:0] swspi_word_t;
	typedef enum logic [1:0] {
		SWSPI_SENSE_OFF,
		SWSPI_SENSE_CH0,
		SWSPI_SENSE_CH1,
		SWSPI_SENSE_TEMP
	} swspi_sense_e;
	typedef enum {
		SWSPI_SLEEP,
		SWSPI_NORMAL,
		SWSPI_FAILSAFE
	} swspi_mode_e;
	typedef enum {
		SWSPI_H_IDLE,
		SWSPI_H_LEAD,
		SWSPI_H_SHIFT,
		SWSPI_H_LAG
	} swspi_hstate_e;
endpackage : swspi_pkg

/* File: src/swspi_if.sv */
`timescale 1ns/10ps
interface swspi_if;
	logic sclk;
	logic chip_select_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic reset_wake_n;
	logic [1:0] dir_in;
	logic [1:0] load_type_input;
	logic pwm_clock;
	logic fault_flag_n_o;
	logic fault_flag_n_oe;
	logic failsafe_flag_n_o;
	logic failsafe_flag_n_oe;
	logic sense_ready_o;
	logic sense_ready_oe;
	logic [1:0] current_sense_output;
	logic current_sense_oe;
	modport device (
		input sclk, chip_select_n, mosi, reset_wake_n, dir_in, load_type_input, pwm_clock,
		output miso, miso_oe, fault_flag_n_o, fault_flag_n_oe, failsafe_flag_n_o,
		output failsafe_flag_n_oe, sense_ready_o, sense_ready_oe, current_sense_output,
		output current_sense_oe
	);
	modport host (
		output sclk, chip_select_n, mosi, reset_wake_n, dir_in, load_type_input, pwm_clock,
		input miso, miso_oe, fault_flag_n_o, fault_flag_n_oe, failsafe_flag_n_o,
		input failsafe_flag_n_oe, sense_ready_o, sense_ready_oe, current_sense_output,
		input current_sense_oe
	);
endinterface : swspi_if

/* File: src/swspi_sync.sv */
`timescale 1ns/10ps
module swspi_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Async in, synced out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			sync_o <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule : swspi_sync

/* File: src/swspi_device.sv */
`timescale 1ns/10ps
`include "swspi_consts.svh"
// Contract
// - Sense select bits pick output, both off tristate
// - Track-hold freezes sense at pre-off value
// - Over-current window disables sense output
// - Sense-ready low when valid, released at turn-off
// - Direct input drives channel unless disabled
// - Rising direct input wakes from sleep
// - Load type 0 bulb, 1 motor profile
// - Any fault pulls fault flag low
// - Per-fault sticky bits, cleared by read
// - External PWM clock monitored, drives PWM
// - Reset low clears all SPI registers
// - Sleep after delay once reset, inputs low; delay timer runs from inputs low only, so reset low can sleep at once
// - Reset rising wakes, starts watchdog
// - Watch bit must toggle before timeout
// - Accept while select low, latch on rise
// - Load output shift on select fall, drive
// - Host keeps sclk low at select edges
// - Sample input falling, shift output rising
// - Sixteen bits, most significant first
// - Address field bits nine to twelve
// - Select high: ignore bus, output tristate
// - Fail-safe flag on lost communication
module swspi_device #(
	parameter int WDTO_CYC = `SWSPI_WDTO_CYC,
	parameter int TIN_CYC = `SWSPI_TIN_CYC,
	parameter int CLKFAIL_CYC = `SWSPI_CLKFAIL_CYC
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Pins
	swspi_if.device pins,
	// Analog-side faults and measurements
	input wire logic [7:0] fault_events_i,
	input wire logic [1:0] oc_window_i,
	input wire logic [1:0] ch_current_i [2],
	input wire logic [1:0] temp_i,
	input wire logic vdd_ok_i,
	// Channel control results
	output logic [1:0] hson_o,
	output logic [1:0] motor_profile_o,
	output logic pwm_tick_o,
	output logic [1:0] mode_o
);
	localparam int W = `SWSPI_WORD_BITS;
	if (WDTO_CYC < 2 || TIN_CYC < 2 || CLKFAIL_CYC < 2) begin : g_bad_counts
		$error("swspi_device: counts too small");
	end
	logic sclk_s, csn_s, mosi_s, rstn_s, pclk_s;
	logic [1:0] din_s, conf_s;
	swspi_sync #(.WIDTH(9)) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({pins.sclk, pins.chip_select_n, pins.mosi, pins.reset_wake_n, pins.pwm_clock,
			pins.dir_in, pins.load_type_input}),
		.sync_o({sclk_s, csn_s, mosi_s, rstn_s, pclk_s, din_s, conf_s})
	);
	logic sclk_d, csn_d, rstn_d, pclk_d;
	logic [1:0] din_d;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sclk_d <= 1'b0;
			csn_d <= 1'b1;
			rstn_d <= 1'b0;
			pclk_d <= 1'b0;
			din_d <= 2'h0;
		end else begin
			sclk_d <= sclk_s;
			csn_d <= csn_s;
			rstn_d <= rstn_s;
			pclk_d <= pclk_s;
			din_d <= din_s;
		end
	end
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire cs_fall = ~csn_s & csn_d;
	wire cs_rise = csn_s & ~csn_d;
	wire rst_rise = rstn_s & ~rstn_d;
	wire [1:0] din_rise = din_s & ~din_d;
	wire [1:0] din_fall = ~din_s & din_d;
	wire regs_clr = ~rstn_s;
	// Register file: index from address field
	logic [W-1:0] regs [`SWSPI_NUM_SO_REGS];
	logic [W-1:0] sh_in_reg, sh_out_reg;
	logic [4:0] bitcnt_reg;
	logic [7:0] fault_sticky_reg;
	function automatic logic [2:0] addr_idx(input logic [W-1:0] w);
		addr_idx = w[`SWSPI_ADDR_HI:`SWSPI_ADDR_LO] > 4'h7 ? 3'h7 :
			w[`SWSPI_ADDR_LO+2:`SWSPI_ADDR_LO];
	endfunction : addr_idx
	wire frame_ok = cs_rise && bitcnt_reg == 5'(W);
	wire [2:0] rd_idx = addr_idx(sh_in_reg);
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sh_in_reg <= '0;
			bitcnt_reg <= 5'h0;
		end else if (csn_s) begin
			bitcnt_reg <= 5'h0;
		end else if (sclk_fall) begin
			sh_in_reg <= {sh_in_reg[W-2:0], mosi_s};
			if (bitcnt_reg != 5'h1f) bitcnt_reg <= bitcnt_reg + 5'h1;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < `SWSPI_NUM_SO_REGS; gi++) begin : g_regs
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i || regs_clr) regs[gi] <= '0;
				else if (frame_ok && rd_idx == 3'(gi)) regs[gi] <= sh_in_reg;
			end
		end
	endgenerate
	// Output shift: index 0 returns sticky faults, others readback
	logic [2:0] so_sel_reg;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sh_out_reg <= '0;
			so_sel_reg <= 3'h0;
		end else if (cs_fall) begin
			sh_out_reg <= so_sel_reg == 3'h0 ? {8'h00, fault_sticky_reg} : regs[so_sel_reg];
		end else if (!csn_s && sclk_rise) begin
			sh_out_reg <= {sh_out_reg[W-2:0], 1'b0};
		end else if (frame_ok) begin
			so_sel_reg <= rd_idx;
		end
	end
	logic miso_reg, miso_oe_reg;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			miso_reg <= 1'b0;
			miso_oe_reg <= 1'b0;
		end else begin
			miso_oe_reg <= ~csn_s & vdd_ok_i;
			miso_reg <= sh_out_reg[W-1];
		end
	end
	// Sticky faults: set wins over read clear
	wire fault_rd = frame_ok && so_sel_reg == 3'h0;
	logic clk_fail;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || regs_clr) fault_sticky_reg <= 8'h00;
		else fault_sticky_reg <= (fault_rd ? 8'h00 : fault_sticky_reg) | fault_events_i |
			{7'h00, clk_fail};
	end
	// External PWM clock monitor
	logic [$clog2(CLKFAIL_CYC+1)-1:0] pclk_cnt_reg;
	wire pclk_edge = pclk_s & ~pclk_d;
	assign clk_fail = pclk_cnt_reg == ($bits(pclk_cnt_reg))'(CLKFAIL_CYC);
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) pclk_cnt_reg <= '0;
		else if (pclk_edge) pclk_cnt_reg <= '0;
		else if (!clk_fail) pclk_cnt_reg <= pclk_cnt_reg + 1'b1;
	end
	// Mode, sleep timer and watchdog
	swspi_pkg::swspi_mode_e mode_reg;
	logic [$clog2(TIN_CYC+1)-1:0] tin_reg;
	logic [$clog2(WDTO_CYC+1)-1:0] wd_reg;
	logic wd_last_reg, wd_run_reg;
	wire wd_toggle = frame_ok && sh_in_reg[`SWSPI_WD_BIT] != wd_last_reg;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode_reg <= swspi_pkg::SWSPI_SLEEP;
			tin_reg <= '0;
			wd_reg <= '0;
			wd_last_reg <= 1'b0;
			wd_run_reg <= 1'b0;
		end else begin
			if (frame_ok) wd_last_reg <= sh_in_reg[`SWSPI_WD_BIT];
			if (din_fall != 2'h0 || din_s != 2'h0) tin_reg <= '0;
			else if (tin_reg != ($bits(tin_reg))'(TIN_CYC)) tin_reg <= tin_reg + 1'b1;
			if (rst_rise || wd_toggle) wd_reg <= '0;
			else if (wd_run_reg && wd_reg != ($bits(wd_reg))'(WDTO_CYC)) wd_reg <= wd_reg + 1'b1;
			case (mode_reg)
				swspi_pkg::SWSPI_SLEEP: begin
					if (rst_rise || din_rise != 2'h0) mode_reg <= swspi_pkg::SWSPI_NORMAL;
					wd_run_reg <= rst_rise;
				end
				swspi_pkg::SWSPI_NORMAL: begin
					if (!rstn_s && din_s == 2'h0 && tin_reg == ($bits(tin_reg))'(TIN_CYC))
						mode_reg <= swspi_pkg::SWSPI_SLEEP;
					else if ((wd_run_reg && wd_reg == ($bits(wd_reg))'(WDTO_CYC)) || !vdd_ok_i)
						mode_reg <= swspi_pkg::SWSPI_FAILSAFE;
					if (rst_rise) wd_run_reg <= 1'b1;
				end
				swspi_pkg::SWSPI_FAILSAFE: begin
					if (!rstn_s && din_s == 2'h0 && tin_reg == ($bits(tin_reg))'(TIN_CYC))
						mode_reg <= swspi_pkg::SWSPI_SLEEP;
					else if (rst_rise) mode_reg <= swspi_pkg::SWSPI_NORMAL;
				end
				default: mode_reg <= swspi_pkg::SWSPI_SLEEP;
			endcase
		end
	end
	// Channel control: reg1 bit0/1 on, bit2/3 direct disable
	wire [1:0] dir_dis = regs[1][3:2];
	wire [1:0] on_bits = regs[1][1:0];
	logic [1:0] hson_prev_reg;
	logic [1:0] held_reg;
	logic sync_low_reg;
	wire [1:0] sel = regs[2][1:0];
	wire [1:0] cur_sel = sel == `SWSPI_SEL_CH0 ? ch_current_i[0] :
		sel == `SWSPI_SEL_CH1 ? ch_current_i[1] : temp_i;
	wire sel_on = sel == `SWSPI_SEL_CH0 ? hson_o[0] : sel == `SWSPI_SEL_CH1 ? hson_o[1] : 1'b1;
	wire track_hold = regs[2][2];
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hson_o <= 2'h0;
			hson_prev_reg <= 2'h0;
			motor_profile_o <= 2'h3;
			pwm_tick_o <= 1'b0;
			mode_o <= 2'h0;
		end else begin
			hson_o <= mode_reg == swspi_pkg::SWSPI_SLEEP ? 2'h0 :
				(din_s & ~dir_dis) | (mode_reg == swspi_pkg::SWSPI_NORMAL ? on_bits : 2'h0);
			hson_prev_reg <= hson_o;
			motor_profile_o <= conf_s;
			pwm_tick_o <= pclk_edge & ~clk_fail;
			mode_o <= 2'(mode_reg);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pins.current_sense_output <= 2'h0;
			pins.current_sense_oe <= 1'b0;
			held_reg <= 2'h0;
			sync_low_reg <= 1'b0;
			pins.fault_flag_n_o <= 1'b0;
			pins.fault_flag_n_oe <= 1'b0;
			pins.failsafe_flag_n_o <= 1'b0;
			pins.failsafe_flag_n_oe <= 1'b0;
			pins.sense_ready_o <= 1'b0;
			pins.sense_ready_oe <= 1'b0;
		end else begin
			if (sel_on) held_reg <= cur_sel;
			pins.current_sense_oe <= sel != `SWSPI_SEL_OFF && (oc_window_i == 2'h0) &&
				vdd_ok_i && mode_reg == swspi_pkg::SWSPI_NORMAL;
			pins.current_sense_output <= (!sel_on && track_hold) ? held_reg : cur_sel;
			// Release on any turn-off of the sensed channel
			sync_low_reg <= sel_on && (hson_prev_reg & hson_o) != 2'h0 &&
				oc_window_i == 2'h0;
			pins.sense_ready_oe <= sync_low_reg;
			pins.fault_flag_n_oe <= fault_sticky_reg != 8'h00;
			pins.failsafe_flag_n_oe <= mode_reg == swspi_pkg::SWSPI_FAILSAFE || !vdd_ok_i;
		end
	end
	assign pins.miso = miso_reg;
	assign pins.miso_oe = miso_oe_reg;
endmodule : swspi_device

/* File: src/swspi_host.sv */
`timescale 1ns/10ps
`include "swspi_consts.svh"
module swspi_host #(
	parameter int HDIV = `SWSPI_HDIV
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Pins
	swspi_if.host pins,
	// User command
	input wire logic start_i,
	input wire logic [14:0] tx_word_i,
	input wire logic wake_i,
	input wire logic [1:0] dir_i,
	input wire logic [1:0] load_type_i,
	input wire logic pwm_clock_i,
	output logic busy_o,
	output logic done_o,
	output logic [15:0] rx_word_o,
	output logic fault_o,
	output logic failsafe_o
);
	if (HDIV < 2) begin : g_bad_div
		$error("swspi_host: HDIV too small");
	end
	swspi_pkg::swspi_hstate_e st_reg;
	logic [$clog2(HDIV+1)-1:0] div_reg;
	logic [4:0] cnt_reg;
	logic [15:0] tx_reg;
	logic wd_reg;
	logic miso_s, flt_s, fs_s;
	swspi_sync #(.WIDTH(3)) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({pins.miso, pins.fault_flag_n_oe, pins.failsafe_flag_n_oe}),
		.sync_o({miso_s, flt_s, fs_s})
	);
	wire tick = div_reg == ($bits(div_reg))'(HDIV - 1);
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || st_reg == swspi_pkg::SWSPI_H_IDLE || tick) div_reg <= '0;
		else div_reg <= div_reg + 1'b1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st_reg <= swspi_pkg::SWSPI_H_IDLE;
			pins.sclk <= 1'b0;
			pins.chip_select_n <= 1'b1;
			pins.mosi <= 1'b0;
			cnt_reg <= 5'h0;
			tx_reg <= 16'h0000;
			wd_reg <= 1'b0;
			rx_word_o <= 16'h0000;
			done_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (st_reg)
				swspi_pkg::SWSPI_H_IDLE: begin
					pins.sclk <= 1'b0;
					if (start_i) begin
						tx_reg <= {wd_reg, tx_word_i};
						wd_reg <= ~wd_reg;
						pins.chip_select_n <= 1'b0;
						busy_o <= 1'b1;
						cnt_reg <= 5'h0;
						st_reg <= swspi_pkg::SWSPI_H_LEAD;
					end
				end
				swspi_pkg::SWSPI_H_LEAD: if (tick) begin
					pins.mosi <= tx_reg[15];
					tx_reg <= {tx_reg[14:0], 1'b0};
					st_reg <= swspi_pkg::SWSPI_H_SHIFT;
				end
				swspi_pkg::SWSPI_H_SHIFT: if (tick) begin
					pins.sclk <= ~pins.sclk;
					if (pins.sclk) begin
						rx_word_o <= {rx_word_o[14:0], miso_s};
						cnt_reg <= cnt_reg + 5'h1;
						if (cnt_reg == 5'd15) st_reg <= swspi_pkg::SWSPI_H_LAG;
					end else if (cnt_reg != 5'h0) begin
						// New bit on the rising edge, stable across the falling sample
						pins.mosi <= tx_reg[15];
						tx_reg <= {tx_reg[14:0], 1'b0};
					end
				end
				swspi_pkg::SWSPI_H_LAG: if (tick) begin
					pins.chip_select_n <= 1'b1;
					busy_o <= 1'b0;
					done_o <= 1'b1;
					st_reg <= swspi_pkg::SWSPI_H_IDLE;
				end
				default: st_reg <= swspi_pkg::SWSPI_H_IDLE;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pins.reset_wake_n <= 1'b0;
			pins.dir_in <= 2'h0;
			pins.load_type_input <= 2'h3;
			pins.pwm_clock <= 1'b0;
			fault_o <= 1'b0;
			failsafe_o <= 1'b0;
		end else begin
			pins.reset_wake_n <= wake_i;
			pins.dir_in <= dir_i;
			pins.load_type_input <= load_type_i;
			pins.pwm_clock <= pwm_clock_i;
			fault_o <= flt_s;
			failsafe_o <= fs_s;
		end
	end
endmodule : swspi_host

/* File: test/swspi_checker.sv */
`timescale 1ns/10ps
module swspi_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Link wires
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic fault_flag_n_o,
	input wire logic failsafe_flag_n_o,
	input wire logic sense_ready_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [4:0] fall_cnt_reg;
	logic wd_bit_reg;
	logic wd_seen_reg;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || chip_select_n) begin
			fall_cnt_reg <= 5'h00;
		end else if ($fell(sclk)) begin
			fall_cnt_reg <= fall_cnt_reg + 5'h01;
		end
	end
	// Only the first bit of a frame feeds the toggle check
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wd_seen_reg <= 1'b0;
			wd_bit_reg <= 1'b0;
		end else if (!chip_select_n && $fell(sclk) && fall_cnt_reg == 5'h00) begin
			wd_seen_reg <= 1'b1;
			wd_bit_reg <= mosi;
		end
	end
	so_tristate_a: assert property (chip_select_n [*5] |-> !miso_oe)
		else $error("serial out driven while deselected");
	so_drive_a: assert property ((!chip_select_n) [*6] |-> miso_oe)
		else $error("serial out not driven while selected");
	sclk_edge_a: assert property ($changed(chip_select_n) |-> !sclk && !$past(sclk))
		else $error("serial clock high at select edge");
	sclk_park_a: assert property (chip_select_n && $past(chip_select_n) |-> !sclk)
		else $error("serial clock not parked low");
	frame_len_a: assert property ($rose(chip_select_n) |-> fall_cnt_reg == 5'h10)
		else $error("frame without sixteen clock falls");
	wd_toggle_a: assert property (
		!chip_select_n && $fell(sclk) && fall_cnt_reg == 5'h00 && wd_seen_reg
		|-> mosi != wd_bit_reg)
		else $error("first bit did not alternate");
	mosi_hold_a: assert property ($fell(sclk) && !chip_select_n |-> $stable(mosi) ##1 $stable(mosi))
		else $error("serial input moved at sampling edge");
	miso_rise_a: assert property (
		miso_oe && $past(miso_oe) && !$past(chip_select_n, 8) && $changed(miso)
		|-> sclk || $past(sclk))
		else $error("serial out moved after falling clock");
	flags_od_a: assert property (!fault_flag_n_o && !failsafe_flag_n_o && !sense_ready_o)
		else $error("open drain flag drives high");
endmodule : swspi_checker

/* File: test/switch_spi_and_control_pins_tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, ac); end end
module switch_spi_and_control_pins_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [14:0] tx = 15'h0000;
	logic wake = 1'b0;
	logic [1:0] dir = 2'h0;
	logic [1:0] lt = 2'h3;
	logic pwm_clk = 1'b0;
	logic pwm_run = 1'b1;
	logic ptick;
	int pcnt;
	logic busy, done, fault, fs;
	logic [15:0] rx;
	logic [7:0] faults = 8'h00;
	logic [1:0] ocw = 2'h0;
	logic [1:0] cur [2] = '{2'h0, 2'h0};
	logic [1:0] temp = 2'h0;
	logic vdd = 1'b1;
	logic [1:0] hson, mp, mode, exp_sense;
	logic [7:0] f;
	logic [16:0] note;
	logic [16:0] note_q [$];
	logic [3:0] r1 [3] = '{4'h0, 4'h4, 4'hd};
	int fail_count = 0;
	int cmp_count = 0;
	always #10 clk = ~clk;
	// Edges land on falling system clock edges, between rising edges, on purpose
	always #80 pwm_clk = pwm_run ? ~pwm_clk : 1'b0;
	swspi_if bus ();
	swspi_host swspi_host_i (.sys_clk_i(clk), .sys_rst_i(rst), .pins(bus), .start_i(start),
		.tx_word_i(tx), .wake_i(wake), .dir_i(dir), .load_type_i(lt), .pwm_clock_i(pwm_clk),
		.busy_o(busy), .done_o(done), .rx_word_o(rx), .fault_o(fault), .failsafe_o(fs));
	swspi_device #(.WDTO_CYC(400), .TIN_CYC(64), .CLKFAIL_CYC(40)) swspi_device_i (
		.sys_clk_i(clk), .sys_rst_i(rst), .pins(bus), .fault_events_i(faults),
		.oc_window_i(ocw), .ch_current_i(cur), .temp_i(temp), .vdd_ok_i(vdd),
		.hson_o(hson), .motor_profile_o(mp), .pwm_tick_o(ptick), .mode_o(mode));
	swspi_checker swspi_checker_i (.sys_clk_i(clk), .sys_rst_i(rst), .sclk(bus.sclk),
		.chip_select_n(bus.chip_select_n), .mosi(bus.mosi), .miso(bus.miso),
		.miso_oe(bus.miso_oe), .fault_flag_n_o(bus.fault_flag_n_o),
		.failsafe_flag_n_o(bus.failsafe_flag_n_o), .sense_ready_o(bus.sense_ready_o));
	task automatic give_verdict;
		$display("Compared %0d, mismatched %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	task automatic tick_n(input int n);
		repeat (n) @(posedge clk);
	endtask : tick_n
	task automatic wait_mode(input logic [1:0] m);
		int n;
		n = 0;
		while (mode !== m && n < 2000) begin
			@(posedge clk);
			n++;
		end
		`CHK("mode", m, mode)
		if (n >= 2000) give_verdict();
	endtask : wait_mode
	// Expected read word is queued before the frame starts
	task automatic xfer(input logic [3:0] addr, input logic [8:0] data, input logic chk,
		input logic [15:0] ex);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		tx <= {2'b00, addr, data};
		start <= 1'b1;
		note_q.push_back({chk, ex});
		@(posedge clk);
		start <= 1'b0;
		while (done !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 1000) begin
			fail_count++;
			$display("[ERR] transfer expected done seen none");
			give_verdict();
		end
	endtask : xfer
	always @(posedge clk) begin
		if (done === 1'b1) begin
			if (note_q.size() == 0) begin
				fail_count++;
				$display("[ERR] rx_word expected none seen %h", rx);
			end else begin
				note = note_q.pop_front();
				if (note[16]) `CHK("rx_word", note[15:0], rx)
			end
		end
	end
	initial begin
		void'($urandom(32'h2132));
		f = 8'($urandom()) | 8'h10;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		tick_n(4);
		wake <= 1'b1;
		wait_mode(2'h1);
		for (int i = 0; i < 4; i++) begin
			lt <= i[1:0];
			tick_n(8);
			`CHK("motor_profile", i[1:0], mp)
		end
		faults <= f;
		xfer(4'h0, 9'h000, 1'b0, 16'h0000);
		`CHK("fault_flag", 1'b1, fault)
		xfer(4'h0, 9'h000, 1'b1, {8'h00, f});
		// Keep the cause up past the latch, so set wins over the read clear
		tick_n(4);
		faults <= 8'h00;
		xfer(4'h0, 9'h000, 1'b1, {8'h00, f});
		xfer(4'h0, 9'h000, 1'b1, 16'h0000);
		`CHK("fault_flag", 1'b0, fault)
		faults <= f;
		xfer(4'h0, 9'h000, 1'b0, 16'h0000);
		tick_n(4);
		faults <= 8'h00;
		wake <= 1'b0;
		tick_n(20);
		wake <= 1'b1;
		tick_n(8);
		xfer(4'h0, 9'h000, 1'b1, 16'h0000);
		pcnt = 0;
		repeat (80) begin
			@(posedge clk);
			if (ptick === 1'b1) pcnt++;
		end
		`CHK("pwm_ticks", 10, pcnt)
		pwm_run <= 1'b0;
		tick_n(60);
		`CHK("fault_flag", 1'b1, fault)
		pwm_run <= 1'b1;
		xfer(4'h0, 9'h000, 1'b1, 16'h0001);
		cur <= '{2'($urandom()), 2'($urandom())};
		temp <= 2'($urandom());
		for (int s = 0; s < 4; s++) begin
			xfer(4'h2, {7'h00, s[1:0]}, 1'b0, 16'h0000);
			tick_n(6);
			exp_sense = (s == 1) ? cur[0] : (s == 2) ? cur[1] : temp;
			`CHK("sense_oe", s != 0, bus.current_sense_oe)
			if (s != 0) `CHK("sense_out", exp_sense, bus.current_sense_output)
		end
		xfer(4'h2, 9'h001, 1'b0, 16'h0000);
		ocw <= 2'h1;
		tick_n(6);
		`CHK("sense_oe", 1'b0, bus.current_sense_oe)
		ocw <= 2'h0;
		xfer(4'h2, 9'h005, 1'b0, 16'h0000);
		exp_sense = 2'($urandom());
		cur <= '{exp_sense, 2'h0};
		dir <= 2'h1;
		tick_n(8);
		`CHK("sense_ready", 1'b1, bus.sense_ready_oe)
		`CHK("sense_out", exp_sense, bus.current_sense_output)
		dir <= 2'h0;
		tick_n(8);
		`CHK("sense_ready", 1'b0, bus.sense_ready_oe)
		cur <= '{~exp_sense, 2'h0};
		tick_n(4);
		`CHK("sense_out", exp_sense, bus.current_sense_output)
		dir <= 2'h3;
		for (int k = 0; k < 3; k++) begin
			xfer(4'h1, {5'h00, r1[k]}, 1'b0, 16'h0000);
			tick_n(8);
			`CHK("hson", (2'h3 & ~r1[k][3:2]) | r1[k][1:0], hson)
		end
		// Address above seven must not reach the channel register
		xfer(4'h9, 9'h000, 1'b0, 16'h0000);
		tick_n(8);
		`CHK("hson", 2'h1, hson)
		vdd <= 1'b0;
		wait_mode(2'h2);
		tick_n(4);
		`CHK("failsafe_flag", 1'b1, fs)
		vdd <= 1'b1;
		wake <= 1'b0;
		tick_n(4);
		wake <= 1'b1;
		wait_mode(2'h1);
		tick_n(300);
		wait_mode(2'h2);
		tick_n(4);
		`CHK("failsafe_flag", 1'b1, fs)
		wake <= 1'b0;
		dir <= 2'h0;
		wait_mode(2'h0);
		dir <= 2'h1;
		wait_mode(2'h1);
		tick_n(10);
		give_verdict();
	end
endmodule : switch_spi_and_control_pins_tb_top
